// ===== dbbp_device.sv
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "dbbp_defines.svh"
module dbbp_device import dbbp_pkg::*; (
  // clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rst_b,
  // core cycle requests
  input  wire logic                   cyc_wr_start,
  input  wire logic                   cyc_rd_start,
  input  wire logic [`DBBP_DATA_W-1:0] cyc_wdata,
  input  wire logic [`DBBP_LANES-1:0]  cyc_be,
  input  wire logic [`DBBP_ADDR_W-1:0] cyc_addr,
  input  wire logic [`DBBP_TYPE_W-1:0] cyc_type,
  input  wire logic                   core_hold,
  // core results
  output logic                        cyc_busy,
  output logic [`DBBP_DATA_W-1:0]     rd_data,
  output logic                        rd_valid,
  output logic                        mc_exception,
  output logic                        irq,
  // register port
  input  wire logic [`DBBP_REG_AW-1:0] reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic [31:0]                 reg_rdata,
  // bus
  dbbp_bus_if.dev                     bus
);
  // ---------------------------------------------------------------
  // cycle sequencing
  // ---------------------------------------------------------------
  dbbp_state_t             state;
  dbbp_lanes_t             be_q;
  logic [`DBBP_ADDR_W-1:0] addr_q;
  logic [`DBBP_TYPE_W-1:0] type_q;
  logic                    take_wr;
  logic                    take_rd;
  logic                    abort;
  logic                    burst_ready;
  dbbp_lanes_t             lane_err;
  logic                    rd_err;
  logic                    pen;
  logic                    machine_check_enable;
  logic [`DBBP_ST_W-1:0]   status;
  logic [`DBBP_ST_W-1:0]   mask;
  logic [`DBBP_ADDR_W-1:0] machine_check_address;
  logic [`DBBP_TYPE_W-1:0] machine_check_type;
  logic [`DBBP_ST_W-1:0]   st_set;
  logic [`DBBP_ST_W-1:0]   st_clr;

  // backoff or hold throws the cycle away; the core reruns it
  assign abort   = !bus.backoff_n || core_hold;
  assign burst_ready    = !bus.burst_ready_n;
  assign take_wr = (state == DBBP_IDLE) && cyc_wr_start && !abort;
  assign take_rd = (state == DBBP_IDLE) && cyc_rd_start && !cyc_wr_start && !abort;
  assign pen     = !bus.parity_check_enable_n;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= DBBP_IDLE;
    end else begin
      case (state)
        DBBP_IDLE: begin
          if (take_wr) state <= DBBP_WRITE;
          else if (take_rd) state <= DBBP_READ;
        end
        DBBP_WRITE, DBBP_READ: begin
          if (abort || burst_ready) state <= DBBP_IDLE;
        end
        default: state <= DBBP_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      be_q   <= 8'h00;
      addr_q <= 32'h00000000;
      type_q <= 8'h00;
    end else if (take_wr || take_rd) begin
      be_q   <= cyc_be;
      addr_q <= cyc_addr;
      type_q <= cyc_type;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) cyc_busy <= 1'b0;
    else cyc_busy <= (take_wr || take_rd) || ((state != DBBP_IDLE) && !(abort || burst_ready));
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      bus.byte_enables_n   <= 8'hFF;
      bus.hold_acknowledge <= 1'b0;
    end else begin
      bus.hold_acknowledge <= core_hold;
      if (take_wr || take_rd) bus.byte_enables_n <= ~cyc_be;
      else if (state == DBBP_IDLE || abort || burst_ready) bus.byte_enables_n <= 8'hFF;
    end
  end

  // ---------------------------------------------------------------
  // write data and parity drive
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      bus.dev_data <= 64'h0000000000000000;
      bus.dev_dp   <= 8'h00;
    end else if (take_wr) begin
      bus.dev_data <= cyc_wdata;
      bus.dev_dp   <= dbbp_parity(cyc_wdata);
    end
  end

  // parity and data enables share one flop update so they move together;
  // hold_acknowledge is registered on the same edge, so no overlap is possible
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      bus.dev_data_oe <= 8'h00;
      bus.dev_dp_oe   <= 8'h00;
    end else if (abort) begin
      bus.dev_data_oe <= 8'h00;
      bus.dev_dp_oe   <= 8'h00;
    end else if (take_wr) begin
      bus.dev_data_oe <= cyc_be;
      bus.dev_dp_oe   <= cyc_be;
    end else if (state == DBBP_WRITE && burst_ready) begin
      bus.dev_data_oe <= 8'h00;
      bus.dev_dp_oe   <= 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // read sampling and check
  // ---------------------------------------------------------------
  always_comb begin
    lane_err = 8'h00;
    for (int i = 0; i < `DBBP_LANES; i++) begin
      lane_err[i] = be_q[i] && ((^bus.data_bus_lines[8*i +: 8]) != bus.data_parity_pins[i]);
    end
  end

  assign rd_err = (state == DBBP_READ) && burst_ready && !abort && (|lane_err);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data  <= 64'h0000000000000000;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= (state == DBBP_READ) && burst_ready && !abort;
      if ((state == DBBP_READ) && burst_ready) rd_data <= bus.data_bus_lines;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) bus.parity_check_status_n <= 1'b1;
    else bus.parity_check_status_n <= !rd_err;
  end

  // ---------------------------------------------------------------
  // machine check capture
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      machine_check_address <= 32'h00000000;
      machine_check_type <= 8'h00;
    end else if (rd_err && pen) begin
      machine_check_address <= addr_q;
      machine_check_type <= type_q;
    end
  end

  // recovery is left to the system; the device only reports
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) mc_exception <= 1'b0;
    else mc_exception <= rd_err && pen && machine_check_enable;
  end

  // ---------------------------------------------------------------
  // registers and interrupt
  // ---------------------------------------------------------------
  always_comb begin
    st_set = 2'h0;
    st_set[`DBBP_ST_PERR] = rd_err && pen;
    st_set[`DBBP_ST_MCHK] = rd_err && pen && machine_check_enable;
    st_clr = 2'h0;
    if (reg_wr && reg_addr == `DBBP_REG_STATUS) st_clr = reg_wdata[`DBBP_ST_W-1:0];
  end

  // set wins over a same-cycle clear so no event is lost
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) status <= 2'h0;
    else status <= (status & ~st_clr) | st_set;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      machine_check_enable  <= `DBBP_CTRL_RST;
      mask <= `DBBP_MASK_RST;
    end else if (reg_wr) begin
      if (reg_addr == `DBBP_REG_CTRL) machine_check_enable <= reg_wdata[`DBBP_CTRL_MCE];
      if (reg_addr == `DBBP_REG_MASK) mask <= reg_wdata[`DBBP_ST_W-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) irq <= 1'b0;
    else irq <= |(((status & ~st_clr) | st_set) & mask);
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        `DBBP_REG_CTRL:   reg_rdata <= {31'h00000000, machine_check_enable};
        `DBBP_REG_STATUS: reg_rdata <= {30'h00000000, status};
        `DBBP_REG_MASK:   reg_rdata <= {30'h00000000, mask};
        `DBBP_REG_MCA:    reg_rdata <= machine_check_address;
        `DBBP_REG_MCT:    reg_rdata <= {24'h000000, machine_check_type};
        default:          reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end
endmodule : dbbp_device
`default_nettype wire

// ===== dbbp_defines.svh
// Contract
// - parity even over byte plus its bit
// - one parity bit per byte lane
// - write parity driven with write data
// - write parity held until burst ready
// - system returns even parity with read data
// - read parity sampled on burst ready clock
// - only enabled byte lanes generated or checked
// - release parity one clock after backoff
// - parity floats while hold acknowledged
// - read check result on status output
// - checking disabled: only status output changes
// - error with checking latches address, type
// - latched error with enable takes exception
// - system acts on errors, device only reports
// - no checking: parity pins, enable pulled high
// - write data driven only in data state
// - system marks each transfer by burst ready
`ifndef DBBP_DEFINES_SVH
`define DBBP_DEFINES_SVH
`define DBBP_LANES      8
`define DBBP_DATA_W     64
`define DBBP_ADDR_W     32
`define DBBP_TYPE_W     8
`define DBBP_REG_AW     8
`define DBBP_REG_CTRL   8'h00
`define DBBP_REG_STATUS 8'h04
`define DBBP_REG_MASK   8'h08
`define DBBP_REG_MCA    8'h0C
`define DBBP_REG_MCT    8'h10
`define DBBP_CTRL_MCE   0
`define DBBP_ST_PERR    0
`define DBBP_ST_MCHK    1
`define DBBP_ST_W       2
`define DBBP_CTRL_RST   1'h0
`define DBBP_MASK_RST   2'h0
`endif

// ===== dbbp_pkg.sv
`include "dbbp_defines.svh"
package dbbp_pkg;
  typedef enum logic [1:0] {
    DBBP_IDLE  = 2'b00,
    DBBP_WRITE = 2'b01,
    DBBP_READ  = 2'b10
  } dbbp_state_t;

  typedef logic [`DBBP_LANES-1:0]  dbbp_lanes_t;
  typedef logic [`DBBP_DATA_W-1:0] dbbp_data_t;

  // even parity bit per byte: data bits plus this bit hold an even count of ones
  function automatic dbbp_lanes_t dbbp_parity(input dbbp_data_t d);
    dbbp_lanes_t p;
    p = '0;
    for (int i = 0; i < `DBBP_LANES; i++) begin
      p[i] = ^d[8*i +: 8];
    end
    return p;
  endfunction : dbbp_parity
endpackage : dbbp_pkg

// ===== dbbp_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "dbbp_defines.svh"
interface dbbp_bus_if import dbbp_pkg::*; ();
  // device side drivers
  dbbp_data_t  dev_data;
  dbbp_lanes_t dev_data_oe;
  dbbp_lanes_t dev_dp;
  dbbp_lanes_t dev_dp_oe;
  dbbp_lanes_t byte_enables_n;
  logic        hold_acknowledge;
  logic        parity_check_status_n;
  // system side drivers
  dbbp_data_t  host_data;
  dbbp_lanes_t host_data_oe;
  dbbp_lanes_t host_dp;
  dbbp_lanes_t host_dp_oe;
  logic        burst_ready_n;
  logic        backoff_n;
  logic        parity_check_enable_n;
  // resolved wire levels; undriven lines read high as through a pullup
  dbbp_data_t  data_bus_lines;
  dbbp_lanes_t data_parity_pins;

  always_comb begin
    for (int i = 0; i < `DBBP_LANES; i++) begin
      data_parity_pins[i] = dev_dp_oe[i] ? dev_dp[i] : (host_dp_oe[i] ? host_dp[i] : 1'b1);
      data_bus_lines[8*i +: 8] = dev_data_oe[i] ? dev_data[8*i +: 8] :
                                 (host_data_oe[i] ? host_data[8*i +: 8] : 8'hFF);
    end
  end

  modport dev (
    output dev_data, dev_data_oe, dev_dp, dev_dp_oe, byte_enables_n, hold_acknowledge,
           parity_check_status_n,
    input  data_bus_lines, data_parity_pins, burst_ready_n, backoff_n, parity_check_enable_n
  );
  modport host (
    output host_data, host_data_oe, host_dp, host_dp_oe, burst_ready_n, backoff_n,
           parity_check_enable_n,
    input  data_bus_lines, data_parity_pins, byte_enables_n, hold_acknowledge,
           parity_check_status_n, dev_dp_oe
  );
endinterface : dbbp_bus_if
`default_nettype wire

// ===== dbbp_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "dbbp_defines.svh"
module dbbp_host import dbbp_pkg::*; (
  // clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rst_b,
  // controller orders
  input  wire logic                   burst_ready_go,
  input  wire logic [`DBBP_DATA_W-1:0] rsp_data,
  input  wire logic [`DBBP_LANES-1:0]  rsp_flip,
  input  wire logic                   backoff_req,
  input  wire logic                   pen_on,
  // controller results
  output logic [`DBBP_DATA_W-1:0]     wr_data,
  output logic [`DBBP_LANES-1:0]      wr_lanes,
  output logic [`DBBP_LANES-1:0]      wr_parity_bad,
  output logic                        wr_valid,
  output logic                        parity_check_status_seen,
  // bus
  dbbp_bus_if.host                    bus
);
  // ---------------------------------------------------------------
  // transfer completion and read return
  // ---------------------------------------------------------------
  logic is_write;
  logic burst_ready;
  assign is_write = |bus.dev_dp_oe;
  assign burst_ready     = !bus.burst_ready_n;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      bus.burst_ready_n <= 1'b1;
      bus.host_data     <= 64'h0000000000000000;
      bus.host_dp       <= 8'h00;
      bus.host_data_oe  <= 8'h00;
      bus.host_dp_oe    <= 8'h00;
    end else begin
      bus.burst_ready_n <= !burst_ready_go;
      bus.host_data_oe  <= 8'h00;
      bus.host_dp_oe    <= 8'h00;
      if (burst_ready_go && !is_write) begin
        bus.host_data    <= rsp_data;
        bus.host_dp      <= dbbp_parity(rsp_data) ^ rsp_flip;
        bus.host_data_oe <= 8'hFF;
        bus.host_dp_oe   <= 8'hFF;
      end
    end
  end

  // ---------------------------------------------------------------
  // write capture, configuration and error report
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_data       <= 64'h0000000000000000;
      wr_lanes      <= 8'h00;
      wr_parity_bad <= 8'h00;
      wr_valid      <= 1'b0;
    end else begin
      wr_valid <= burst_ready && is_write;
      if (burst_ready && is_write) begin
        wr_data       <= bus.data_bus_lines;
        wr_lanes      <= bus.dev_dp_oe;
        wr_parity_bad <= bus.dev_dp_oe & (dbbp_parity(bus.data_bus_lines) ^ bus.data_parity_pins);
      end
    end
  end

  // with checking off the enable stays high, like the pulled-up pin
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      bus.backoff_n             <= 1'b1;
      bus.parity_check_enable_n <= 1'b1;
      parity_check_status_seen                 <= 1'b0;
    end else begin
      bus.backoff_n             <= !backoff_req;
      bus.parity_check_enable_n <= !pen_on;
      parity_check_status_seen                 <= !bus.parity_check_status_n;
    end
  end
endmodule : dbbp_host
`default_nettype wire

// ===== dbbp_properties.sv
`timescale 1ns/1ps
`default_nettype none
module dbbp_properties import dbbp_pkg::*; (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_b,
  // device side
  input wire dbbp_data_t  dev_data,
  input wire dbbp_lanes_t dev_data_oe,
  input wire dbbp_lanes_t dev_dp,
  input wire dbbp_lanes_t dev_dp_oe,
  input wire dbbp_lanes_t byte_enables_n,
  input wire logic        hold_acknowledge,
  input wire logic        parity_check_status_n,
  // system side and resolved wire
  input wire logic        burst_ready_n,
  input wire logic        backoff_n,
  input wire dbbp_data_t  data_bus_lines,
  input wire dbbp_lanes_t data_parity_pins
);
  dbbp_lanes_t wr_bad;
  dbbp_lanes_t rd_err;
  logic        rd_bad;

  // lane i pairs data bits 8i+7..8i with parity bit i
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      wr_bad[i] = dev_dp_oe[i] & (dev_dp[i] ^ (^dev_data[8*i +: 8]));
      rd_err[i] = ~byte_enables_n[i] & (data_parity_pins[i] ^ (^data_bus_lines[8*i +: 8]));
    end
  end
  assign rd_bad = |rd_err;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  a_wr_even_par: assert property (wr_bad == 8'h00) else $error("odd write parity");
  a_par_with_data: assert property (dev_dp_oe == dev_data_oe) else $error("parity apart from data");
  a_wr_par_held: assert property (|dev_dp_oe && burst_ready_n && backoff_n |=>
    hold_acknowledge || ($stable(dev_dp) && $stable(dev_dp_oe))) else $error("write parity moved");
  a_burst_ready_release: assert property (|dev_dp_oe && !burst_ready_n |=> dev_dp_oe == 8'h00)
    else $error("parity kept after ready");
  a_backoff_float: assert property (!backoff_n |=> dev_dp_oe == 8'h00 && dev_data_oe == 8'h00)
    else $error("no float after backoff");
  a_hold_float: assert property (hold_acknowledge |-> dev_dp_oe == 8'h00 && dev_data_oe == 8'h00)
    else $error("driving in hold");
  a_lane_enable: assert property ((dev_dp_oe & byte_enables_n) == 8'h00) else $error("disabled lane driven");
  // a backoff in the ready clock abandons the read, so no check result is due then
  a_rd_status: assert property (!burst_ready_n && backoff_n && dev_dp_oe == 8'h00 |=>
    parity_check_status_n == !$past(rd_bad))
    else $error("wrong read check status");
  a_status_cause: assert property (!parity_check_status_n |-> $past(burst_ready_n) == 1'b0)
    else $error("status without ready");

  c_write_done: cover property (|dev_dp_oe && !burst_ready_n);
  c_read_error: cover property (!parity_check_status_n);
  c_backoff: cover property (|dev_dp_oe ##1 !backoff_n);
  c_hold: cover property (hold_acknowledge);
endmodule : dbbp_properties
`default_nettype wire

// ===== tb_data_bus_byte_parity.sv
`timescale 1ns/1ps
`default_nettype none
module tb_data_bus_byte_parity import dbbp_pkg::*; ();
  typedef struct {logic wr; logic [31:0] addr; logic [63:0] data; logic [7:0] be, flip; logic parity_check_status;} dbbp_row_t;
  logic        ref_clk, rst_b, cyc_wr_start, cyc_rd_start, core_hold, reg_wr, reg_rd;
  logic        burst_ready_go, backoff_req, pen_on, cyc_busy, rd_valid, mc_exception, irq, wr_valid, parity_check_status_seen;
  logic [63:0] cyc_wdata, rsp_data, rd_data, wr_data;
  logic [31:0] cyc_addr, reg_wdata, reg_rdata, d;
  logic [7:0]  cyc_be, cyc_type, reg_addr, rsp_flip, wr_lanes, wr_parity_bad;
  int          errors, check_count;
  dbbp_row_t   rows [5] = '{
    '{1'b1, 32'h0000_1000, 64'h0123_4567_89AB_CDEF, 8'hFF, 8'h00, 1'b0},
    '{1'b1, 32'h0000_2008, 64'hFF00_A5A5_0F0F_7E81, 8'h81, 8'h00, 1'b0},
    '{1'b0, 32'h0000_3010, 64'hDEAD_BEEF_CAFE_F00D, 8'hFF, 8'h00, 1'b0},
    '{1'b0, 32'h0000_4018, 64'h1122_3344_5566_7788, 8'h3C, 8'hC3, 1'b0},
    '{1'b0, 32'h0000_5020, 64'h8000_0000_0000_0001, 8'hFF, 8'h08, 1'b1}};

  dbbp_bus_if dbbp_bus_if_i ();
  dbbp_device dbbp_device_i (.ref_clk, .rst_b, .cyc_wr_start, .cyc_rd_start, .cyc_wdata, .cyc_be, .cyc_addr,
    .cyc_type, .core_hold, .cyc_busy, .rd_data, .rd_valid, .mc_exception, .irq, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .bus(dbbp_bus_if_i.dev));
  dbbp_host dbbp_host_i (.ref_clk, .rst_b, .burst_ready_go, .rsp_data, .rsp_flip, .backoff_req, .pen_on, .wr_data,
    .wr_lanes, .wr_parity_bad, .wr_valid, .parity_check_status_seen, .bus(dbbp_bus_if_i.host));
  dbbp_properties dbbp_properties_i (.ref_clk, .rst_b, .dev_data(dbbp_bus_if_i.dev_data),
    .dev_data_oe(dbbp_bus_if_i.dev_data_oe), .dev_dp(dbbp_bus_if_i.dev_dp), .dev_dp_oe(dbbp_bus_if_i.dev_dp_oe),
    .byte_enables_n(dbbp_bus_if_i.byte_enables_n), .hold_acknowledge(dbbp_bus_if_i.hold_acknowledge),
    .parity_check_status_n(dbbp_bus_if_i.parity_check_status_n), .burst_ready_n(dbbp_bus_if_i.burst_ready_n),
    .backoff_n(dbbp_bus_if_i.backoff_n), .data_bus_lines(dbbp_bus_if_i.data_bus_lines),
    .data_parity_pins(dbbp_bus_if_i.data_parity_pins));

  always #50 ref_clk = ~ref_clk;

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic report_and_stop();
    if (errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  task automatic rwr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : rwr

  // read data stand only in the cycle after the strobe
  task automatic rrd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rrd

  task automatic start(input dbbp_row_t r);
    @(posedge ref_clk);
    cyc_wr_start <= r.wr;
    cyc_rd_start <= !r.wr;
    cyc_wdata    <= r.data;
    rsp_data     <= r.data;
    cyc_be       <= r.be;
    rsp_flip     <= r.flip;
    cyc_addr     <= r.addr;
    cyc_type     <= r.addr[7:0];
    @(posedge ref_clk);
    cyc_wr_start <= 1'b0;
    cyc_rd_start <= 1'b0;
  endtask : start

  task automatic xfer(input dbbp_row_t r);
    logic [63:0] m;
    for (int i = 0; i < 8; i++) m[8*i +: 8] = {8{r.be[i]}};
    start(r);
    burst_ready_go <= 1'b1;
    @(posedge ref_clk);
    burst_ready_go <= 1'b0;
    @(posedge ref_clk);
    #1;
    if (r.wr) begin
      chk("wr_valid", wr_valid, 64'h1);
      chk("wr_lanes", wr_lanes, r.be);
      chk("wr_data", wr_data & m, r.data & m);
      chk("wr_parity_bad", wr_parity_bad & r.be, 64'h0);
    end else begin
      chk("rd_valid", rd_valid, 64'h1);
      chk("rd_data", rd_data & m, r.data & m);
      chk("mc_exception", mc_exception, r.parity_check_status & pen_on);
    end
    @(posedge ref_clk);
    #1;
    chk("parity_check_status_seen", parity_check_status_seen, r.parity_check_status);
  endtask : xfer

  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    {ref_clk, rst_b, cyc_wr_start, cyc_rd_start, core_hold, reg_wr, reg_rd, burst_ready_go, backoff_req} = '0;
    {cyc_wdata, rsp_data, cyc_addr, reg_wdata, cyc_be, cyc_type, reg_addr, rsp_flip} = '0;
    errors = 0;
    check_count = 0;
    pen_on = 1'b1;
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    for (int a = 0; a < 20; a += 4) begin
      rrd(8'(a));
      chk("reset reg", d, 64'h0);
    end
    rrd(8'h20);
    chk("unmapped", d, 64'h0);
    rwr(8'h00, 32'h1);
    foreach (rows[i]) xfer(rows[i]);
    rrd(8'h04);
    chk("status", d, 64'h3);
    rrd(8'h0C);
    chk("mca", d, 64'h5020);
    rrd(8'h10);
    chk("mct", d, 64'h20);
    chk("irq masked", irq, 64'h0);
    rwr(8'h08, 32'h1);
    rrd(8'h08);
    chk("mask", d, 64'h1);
    chk("irq", irq, 64'h1);
    rwr(8'h04, 32'h1);
    rrd(8'h04);
    chk("status w1c", d, 64'h2);
    chk("irq cleared", irq, 64'h0);
    rwr(8'h04, 32'h2);
    // checking off: only the status pin may react
    pen_on <= 1'b0;
    repeat (2) @(posedge ref_clk);
    xfer('{1'b0, 32'h0000_6028, 64'h0, 8'hFF, 8'h01, 1'b1});
    rrd(8'h04);
    chk("status pen off", d, 64'h0);
    rrd(8'h0C);
    chk("mca pen off", d, 64'h5020);
    start(rows[0]);
    backoff_req <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    chk("backoff oe", dbbp_bus_if_i.dev_dp_oe, 64'h0);
    chk("backoff busy", cyc_busy, 64'h0);
    backoff_req <= 1'b0;
    repeat (2) @(posedge ref_clk);
    start(rows[0]);
    core_hold <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    chk("hold ack", dbbp_bus_if_i.hold_acknowledge, 64'h1);
    chk("hold oe", dbbp_bus_if_i.dev_dp_oe, 64'h0);
    core_hold <= 1'b0;
    repeat (3) @(posedge ref_clk);
    // mid-run reset must drop control, mask and the captured address and type
    rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    rst_b <= 1'b1;
    for (int a = 0; a < 20; a += 4) begin
      rrd(8'(a));
      chk("rerun reset reg", d, 64'h0);
    end
    report_and_stop();
  end

  initial begin
    repeat (3000) @(posedge ref_clk);
    errors++;
    report_and_stop();
  end
endmodule : tb_data_bus_byte_parity
`default_nettype wire
